// file: rtl/pocr_regs.vh
// register map, field positions and reset values of the port
// over-current configuration bank; included by the design files
`ifndef POCR_REGS_VH
`define POCR_REGS_VH

// register indices; byte address is index times four
`define POCR_IDX_SRC1      16'h3C20
`define POCR_IDX_SRC2      16'h3C24
`define POCR_IDX_SRC3      16'h3C28
`define POCR_IDX_SRC4      16'h3C2C
`define POCR_IDX_CHARGE    16'h5246
`define POCR_IDX_SHARE     16'h525A
`define POCR_IDX_PINSEL    16'h525B
`define POCR_IDX_IRQ_STAT  16'h7000
`define POCR_IDX_IRQ_MASK  16'h7001
`define POCR_IDX_OC_STAT   16'h7002

// field positions
`define POCR_SRC_MSB       3
`define POCR_SRC_LSB       0
`define POCR_CHARGE_LSB    0
`define POCR_SHARE_LSB     1
`define POCR_PINSEL_MSB    5
`define POCR_PINSEL_LSB    0
`define POCR_IRQ_OC_LSB    0
`define POCR_IRQ_CHG_LSB   4

// over-current source encodings
`define POCR_SRC_OFF       4'h0
`define POCR_SRC_PIN       4'h1
`define POCR_SRC_GPIO      4'h2
`define POCR_SRC_FORCE     4'hF

// reset values
`define POCR_RST_SRC       8'h00
`define POCR_RST_CHARGE    8'h00
`define POCR_RST_SHARE     8'h00
`define POCR_RST_PINSEL    8'h00
`define POCR_RST_IRQ       8'h00

`endif

// file: rtl/pocr_port_sense.v
// one port's over-current source selection and rising-edge event
// assumes sense inputs are synchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "pocr_regs.vh"

module pocr_port_sense #(
	parameter SEL_W = 4
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// configuration
	input  wire [SEL_W-1:0] source_sel,
	// sense inputs
	input  wire             sense_pin,
	input  wire             gpio_pin,
	// results
	output reg              overcurrent,
	output reg              overcurrent_rise,
	output wire             enabled
);

	reg next_overcurrent;

	assign enabled = (source_sel != `POCR_SRC_OFF);

	always @*
	begin
		case (source_sel)
			`POCR_SRC_OFF:   next_overcurrent = 1'b0;
			`POCR_SRC_PIN:   next_overcurrent = sense_pin;
			`POCR_SRC_GPIO:  next_overcurrent = gpio_pin;
			`POCR_SRC_FORCE: next_overcurrent = 1'b1;
			default:         next_overcurrent = 1'b0;
		endcase
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			overcurrent      <= 1'b0;
			overcurrent_rise <= 1'b0;
		end
		else
		begin
			overcurrent      <= next_overcurrent;
			overcurrent_rise <= next_overcurrent & ~overcurrent;
		end
	end

endmodule // pocr_port_sense
`default_nettype wire

// file: rtl/pocr_top.v
// port over-current configuration and charging-detect register bank
// classic wishbone slave, 8-bit registers in the low byte lane
// assumes all inputs synchronous to clk
// assumes source fields are loaded before ports are used
// register index is the byte address divided by four
`timescale 1ns/100ps
`default_nettype none
`include "pocr_regs.vh"

module pocr_top #(
	parameter PORTS = 4
) (
	// clock and reset
	input  wire              clk,
	input  wire              rst,
	// wishbone slave
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [31:0]       wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	output reg               wb_ack_o,
	// over-current sense inputs
	input  wire [PORTS-1:0]  overcurrent_sense,
	input  wire [PORTS-1:0]  overcurrent_gpio,
	// charging handshake inputs
	input  wire [PORTS-1:0]  charging_handshake_seen,
	input  wire              hub_enumerated,
	// port results
	output wire [PORTS-1:0]  port_overcurrent,
	output reg  [PORTS-1:0]  port_enabled,
	// shared over-current pin
	output reg               shared_overcurrent,
	output reg  [PORTS-1:0]  port_share_enable,
	output reg  [5:0]        shared_sense_pin_field,
	// interrupt
	output wire              irq
);

	// stored registers
	reg  [7:0]       source_cfg [0:PORTS-1];
	reg  [7:0]       charging_host_detected;
	reg  [7:0]       overcurrent_share_control;
	reg  [7:0]       shared_pin_select;
	reg  [7:0]       irq_status;
	reg  [7:0]       irq_mask;

	// next values
	reg  [7:0]       next_charging;
	reg  [7:0]       next_irq_status;
	reg  [7:0]       read_mux;

	// bus decode
	wire             bus_req;
	wire [15:0]      reg_index;
	wire             addr_ok;
	wire             wr_commit;
	wire [7:0]       wr_byte;
	wire [PORTS-1:0] hit_source;
	wire             hit_charge;
	wire             hit_share;
	wire             hit_pinsel;
	wire             hit_irq_stat;
	wire             hit_irq_mask;
	wire             hit_oc_stat;

	// per-port results
	wire [PORTS-1:0] oc_rise;
	wire [PORTS-1:0] port_on;
	wire [PORTS-1:0] charge_event;
	wire [PORTS-1:0] share_bits;

	assign bus_req   = wb_cyc_i & wb_stb_i;
	assign reg_index = wb_adr_i[17:2];
	assign addr_ok   = (wb_adr_i[31:18] == 14'h0000) && (wb_adr_i[1:0] == 2'b00);

	// a write lands on the edge where the master sees ack
	assign wr_commit = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
	assign wr_byte   = wb_dat_i[7:0];

	// one hit per register; misaligned or high addresses miss
	assign hit_source[0] = addr_ok && (reg_index == `POCR_IDX_SRC1);
	assign hit_source[1] = addr_ok && (reg_index == `POCR_IDX_SRC2);
	assign hit_source[2] = addr_ok && (reg_index == `POCR_IDX_SRC3);
	assign hit_source[3] = addr_ok && (reg_index == `POCR_IDX_SRC4);
	assign hit_charge    = addr_ok && (reg_index == `POCR_IDX_CHARGE);
	assign hit_share     = addr_ok && (reg_index == `POCR_IDX_SHARE);
	assign hit_pinsel    = addr_ok && (reg_index == `POCR_IDX_PINSEL);
	assign hit_irq_stat  = addr_ok && (reg_index == `POCR_IDX_IRQ_STAT);
	assign hit_irq_mask  = addr_ok && (reg_index == `POCR_IDX_IRQ_MASK);
	assign hit_oc_stat   = addr_ok && (reg_index == `POCR_IDX_OC_STAT);

	// one answer per request, ack drops the cycle after
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req & ~wb_ack_o;
	end

	// read data captured with ack, unmapped reads zero
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			wb_dat_o <= 32'h00000000;
		else if (bus_req & ~wb_ack_o)
			wb_dat_o <= {24'h000000, read_mux};
	end

	// read decode; reserved bits read back as stored
	always @*
	begin
		read_mux = 8'h00;
		if (hit_source[0])
			read_mux = source_cfg[0];
		else if (hit_source[1])
			read_mux = source_cfg[1];
		else if (hit_source[2])
			read_mux = source_cfg[2];
		else if (hit_source[3])
			read_mux = source_cfg[3];
		else if (hit_charge)
			read_mux = charging_host_detected;
		else if (hit_share)
			read_mux = overcurrent_share_control;
		else if (hit_pinsel)
			read_mux = shared_pin_select;
		else if (hit_irq_stat)
			read_mux = irq_status;
		else if (hit_irq_mask)
			read_mux = irq_mask;
		else if (hit_oc_stat)
			read_mux = {port_enabled, port_overcurrent};
	end

	// per-port source select registers, upper nibble kept but unused
	genvar k;
	generate
		for (k = 0; k < PORTS; k = k + 1)
		begin : g_port
			always @(posedge clk or posedge rst)
			begin
				if (rst)
					source_cfg[k] <= `POCR_RST_SRC;
				else if (wr_commit && hit_source[k])
					source_cfg[k] <= wr_byte;
			end

			pocr_port_sense #(
				.SEL_W (4)
			) pocr_port_sense_i (
				.clk              (clk),
				.rst              (rst),
				.source_sel       (source_cfg[k][`POCR_SRC_MSB:`POCR_SRC_LSB]),
				.sense_pin        (overcurrent_sense[k]),
				.gpio_pin         (overcurrent_gpio[k]),
				.overcurrent      (port_overcurrent[k]),
				.overcurrent_rise (oc_rise[k]),
				.enabled          (port_on[k])
			);
		end
	endgenerate

	// registered so enable lines up with over-current
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			port_enabled <= {PORTS{1'b0}};
		else
			port_enabled <= port_on;
	end

	// handshake only counts before the hub has enumerated
	assign charge_event = charging_handshake_seen & {PORTS{~hub_enumerated}};

	// detection sets win over a software write in the same cycle
	always @*
	begin
		if (wr_commit && hit_charge)
			next_charging = wr_byte;
		else
			next_charging = charging_host_detected;
		next_charging[`POCR_CHARGE_LSB +: PORTS] =
			next_charging[`POCR_CHARGE_LSB +: PORTS] | charge_event;
	end

	// detect bits held until software overwrites them
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			charging_host_detected <= `POCR_RST_CHARGE;
		else
			charging_host_detected <= next_charging;
	end

	// share control, reserved bits stored
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			overcurrent_share_control <= `POCR_RST_SHARE;
		else if (wr_commit && hit_share)
			overcurrent_share_control <= wr_byte;
	end

	// shared pin selection; only valid codes are expected here
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			shared_pin_select <= `POCR_RST_PINSEL;
		else if (wr_commit && hit_pinsel)
			shared_pin_select <= wr_byte;
	end

	assign share_bits = overcurrent_share_control[`POCR_SHARE_LSB +: PORTS];

	// ganged ports drive one combined status onto the chosen pin
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			shared_overcurrent     <= 1'b0;
			port_share_enable      <= {PORTS{1'b0}};
			shared_sense_pin_field <= 6'h00;
		end
		else
		begin
			shared_overcurrent     <= |(port_overcurrent & share_bits);
			port_share_enable      <= share_bits;
			shared_sense_pin_field <=
				shared_pin_select[`POCR_PINSEL_MSB:`POCR_PINSEL_LSB];
		end
	end

	// interrupt status: write one to clear, new events win
	// bits 3:0 over-current rises, bits 7:4 charging events
	always @*
	begin
		next_irq_status = irq_status;
		if (wr_commit && hit_irq_stat)
			next_irq_status = irq_status & ~wr_byte;
		next_irq_status[`POCR_IRQ_OC_LSB +: PORTS] =
			next_irq_status[`POCR_IRQ_OC_LSB +: PORTS] | oc_rise;
		next_irq_status[`POCR_IRQ_CHG_LSB +: PORTS] =
			next_irq_status[`POCR_IRQ_CHG_LSB +: PORTS] | charge_event;
	end

	// sticky status, one flop per event bit
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			irq_status <= `POCR_RST_IRQ;
		else
			irq_status <= next_irq_status;
	end

	// mask has the status layout; a one lets the bit through
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			irq_mask <= `POCR_RST_IRQ;
		else if (wr_commit && hit_irq_mask)
			irq_mask <= wr_byte;
	end

	// level output, follows status in the same cycle
	assign irq = |(irq_status & irq_mask);

endmodule // pocr_top
`default_nettype wire

// file: sim/pocr_top_assertions.sv
// checker on the ports of pocr_top, bound to every instance
// assumes one clock domain and asynchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module pocr_checker #(
	parameter PORTS = 4
) (
	// clock and reset
	input wire logic             clk,
	input wire logic             rst,
	// bus
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [31:0]      wb_adr_i,
	input wire logic [3:0]       wb_sel_i,
	input wire logic [31:0]      wb_dat_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wb_ack_o,
	// port pins
	input wire logic [PORTS-1:0] overcurrent_sense,
	input wire logic [PORTS-1:0] overcurrent_gpio,
	input wire logic [PORTS-1:0] port_overcurrent,
	input wire logic [PORTS-1:0] port_enabled,
	input wire logic [PORTS-1:0] port_share_enable,
	input wire logic             shared_overcurrent
);
	logic [15:0]      src;
	logic [PORTS-1:0] exp_oc;
	logic [PORTS-1:0] exp_en;
	// shadow of the four source fields
	always_ff @(posedge clk or posedge rst)
		if (rst)
			src <= 16'h0000;
		else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
			&& wb_adr_i[31:6] == 26'h00003C2 && wb_adr_i[3:0] == 4'h0)
			src[wb_adr_i[5:4]*4 +: 4] <= wb_dat_i[3:0];
	always_comb
		for (int i = 0; i < PORTS; i++)
		begin
			exp_en[i] = src[i*4 +: 4] != 4'h0;
			case (src[i*4 +: 4])
				4'h1: exp_oc[i] = overcurrent_sense[i];
				4'h2: exp_oc[i] = overcurrent_gpio[i];
				4'hF: exp_oc[i] = 1'b1;
				default: exp_oc[i] = 1'b0;
			endcase
		end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	src_enable_a: assert property (port_enabled == $past(exp_en))
		else $error("port enable differs from source field");
	src_select_a: assert property (port_overcurrent == $past(exp_oc))
		else $error("over-current differs from selected source");
	off_quiet_a: assert property ((port_overcurrent & ~port_enabled) == '0)
		else $error("disabled port shows over-current");
	share_route_a: assert property ($stable(port_share_enable) |->
		shared_overcurrent == $past(|(port_overcurrent & port_share_enable)))
		else $error("shared over-current wrong");
	cover property (wb_ack_o && wb_we_i);
	cover property ($rose(shared_overcurrent));
	cover property ($rose(port_enabled[0]));
endmodule // pocr_checker

bind pocr_top pocr_checker #(.PORTS(PORTS)) pocr_checker_i (.clk, .rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.overcurrent_sense, .overcurrent_gpio, .port_overcurrent, .port_enabled,
	.port_share_enable, .shared_overcurrent);
`default_nettype wire

// file: sim/pocr_top_test.sv
// self-checking bench for pocr_top over classic wishbone
// the bench drives every input itself, no partner model
`timescale 1ns/100ps
`default_nettype none
`include "pocr_regs.vh"
module pocr_top_test;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, hub = 1'b0;
	logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
	logic [3:0]  sel = 4'h0, sense = 4'h0, gpio = 4'h0, hs = 4'h0, poc, pen, pse;
	logic        ack, soc, irq;
	logic [5:0]  pin;
	logic [7:0]  q;
	int          miscompares = 0, check_count = 0;
	always #2.5 clk = ~clk;
	pocr_top #(.PORTS(4)) pocr_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .overcurrent_sense(sense), .overcurrent_gpio(gpio),
		.charging_handshake_seen(hs), .hub_enumerated(hub), .port_overcurrent(poc),
		.port_enabled(pen), .shared_overcurrent(soc), .port_share_enable(pse),
		.shared_sense_pin_field(pin), .irq(irq));
	task test_done;
		if (miscompares == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string name, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, e, g);
		end
	endtask
	task bus(input logic [31:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		sel <= 4'hF;
		n = 0;
		@(posedge clk);
		while (ack !== 1'b1 && n < 16)
		begin
			@(posedge clk);
			n++;
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 16)
		begin
			miscompares++;
			test_done;
		end
	endtask
	task rd(input logic [31:0] a, input logic [7:0] e, input string name);
		bus(a, 1'b0, 8'h00);
		chk(name, e, q);
	endtask
	task src_modes;
		logic [3:0] codes [4];
		logic [3:0] oc;
		codes = '{4'h0, 4'h1, 4'h2, 4'hF};
		rd(`POCR_IDX_SRC1 * 4, 8'h00, "source_reset");
		sense <= 4'h5;
		gpio <= 4'hA;
		for (int c = 0; c < 4; c++)
		begin
			for (int p = 0; p < 4; p++)
				bus(`POCR_IDX_SRC1 * 4 + p * 16, 1'b1, {4'hA, codes[c]});
			repeat (3) @(posedge clk);
			oc = codes[c] == 4'h1 ? 4'h5 : codes[c] == 4'h2 ? 4'hA : {4{codes[c] == 4'hF}};
			chk("port_overcurrent", {4'h0, oc}, {4'h0, poc});
			chk("port_enabled", {4'h0, {4{codes[c] != 4'h0}}}, {4'h0, pen});
			rd(`POCR_IDX_SRC4 * 4, {4'hA, codes[c]}, "source_reg");
		end
	endtask
	task share_route;
		for (int p = 0; p < 4; p++)
			bus(`POCR_IDX_SRC1 * 4 + p * 16, 1'b1, 8'h01);
		bus(`POCR_IDX_SHARE * 4, 1'b1, 8'h14);
		bus(`POCR_IDX_PINSEL * 4, 1'b1, 8'hC6);
		rd(`POCR_IDX_PINSEL * 4, 8'hC6, "pin_select");
		chk("port_share_enable", 8'h0A, {4'h0, pse});
		chk("shared_sense_pin_field", 8'h06, {2'b00, pin});
		for (int s = 0; s < 4; s++)
		begin
			sense <= 4'h1 << s;
			repeat (3) @(posedge clk);
			chk("shared_overcurrent", {7'h00, s[0]}, {7'h00, soc});
		end
	endtask
	task charge_detect;
		hub <= 1'b1;
		hs <= 4'h1;
		@(posedge clk);
		hs <= 4'h0;
		hub <= 1'b0;
		rd(`POCR_IDX_CHARGE * 4, 8'h00, "charge_ignored");
		hs <= 4'h4;
		@(posedge clk);
		hs <= 4'h0;
		repeat (4) @(posedge clk);
		rd(`POCR_IDX_CHARGE * 4, 8'h04, "charge_held");
		bus(`POCR_IDX_CHARGE * 4, 1'b1, 8'hF0);
		rd(`POCR_IDX_CHARGE * 4, 8'hF0, "charge_overwrite");
	endtask
	task irq_flow;
		sense <= 4'h0;
		repeat (3) @(posedge clk);
		bus(`POCR_IDX_IRQ_STAT * 4, 1'b1, 8'hFF);
		bus(`POCR_IDX_IRQ_MASK * 4, 1'b1, 8'h01);
		rd(`POCR_IDX_IRQ_STAT * 4, 8'h00, "irq_status_clear");
		chk("irq_idle", 8'h00, {7'h00, irq});
		sense <= 4'h3;
		repeat (3) @(posedge clk);
		chk("irq_raised", 8'h01, {7'h00, irq});
		rd(`POCR_IDX_IRQ_STAT * 4, 8'h03, "irq_status");
		rd(`POCR_IDX_OC_STAT * 4, 8'hF3, "oc_status");
		bus(`POCR_IDX_IRQ_STAT * 4, 1'b1, 8'h01);
		@(posedge clk);
		chk("irq_masked", 8'h00, {7'h00, irq});
		rd(`POCR_IDX_IRQ_STAT * 4, 8'h02, "irq_status_left");
		rd(32'h00000004, 8'h00, "unmapped");
		rd(`POCR_IDX_SRC1 * 4 + 1, 8'h00, "misaligned");
	endtask
	task reset_again;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`POCR_IDX_SRC1 * 4, 8'h00, "source_after_reset");
		rd(`POCR_IDX_IRQ_STAT * 4, 8'h00, "irq_after_reset");
		chk("enabled_after_reset", 8'h00, {4'h0, pen});
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		src_modes;
		share_route;
		charge_detect;
		irq_flow;
		reset_again;
		test_done;
	end
endmodule // pocr_top_test
`default_nettype wire
